// ---- dv/uart_register_map_rx_tx_buffers_bench.sv ----
// Testbench for the serial port register front end
`timescale 1ns/10ps
`default_nettype none
module uart_register_map_rx_tx_buffers_bench;
  localparam logic [31:0] B = urm_pkg::BASE_ADDR;
  logic clk = 1'h0, nrst = 1'h0, awv = 1'h0, wv = 1'h0, arv = 1'h0;
  logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, rdat;
  logic [1:0] br, rr;
  logic brdy = 1'h0, rrdy = 1'h0;
  logic awr, wrdy, bv, arr, rv, txd, rxd;
  int fails = 0;
  int cmp_count = 0;
  always #25 clk = ~clk;
  urm_top dut(.CLK_SYS(clk), .NRST(nrst), .AWADDR(awa), .AWVALID(awv),
    .AWREADY(awr), .WDATA(wd), .WSTRB(4'hf), .WVALID(wv), .WREADY(wrdy),
    .BRESP(br), .BVALID(bv), .BREADY(brdy), .ARADDR(ara), .ARVALID(arv),
    .ARREADY(arr), .RDATA(rdat), .RRESP(rr), .RVALID(rv), .RREADY(rrdy),
    .RXD(rxd), .TXD(txd));
  urm_serial_peer peer(.clk(clk), .txd(txd), .rxd(rxd));
  task automatic give_verdict;
    if (fails == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic stall;
    fails++;
    give_verdict;
  endtask
  task automatic chk(input string n, input logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (e !== g) begin
      $display("Error %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask
  task automatic wr(input logic [31:0] o, input logic [31:0] d,
      input logic [1:0] e = urm_pkg::RESP_OKAY);
    int n;
    n = 0;
    awa <= B + o;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    brdy <= 1'h1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'h0;
      if (wrdy) wv <= 1'h0;
      n++;
    end while (!bv && n < 50);
    if (!bv) stall();
    chk("bresp", 32'(e), 32'(br));
    brdy <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d,
      output logic [1:0] r);
    int n;
    n = 0;
    ara <= a;
    arv <= 1'h1;
    rrdy <= 1'h1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'h0;
      n++;
    end while (!rv && n < 50);
    if (!rv) stall();
    d = rdat;
    r = rr;
    rrdy <= 1'h0;
    @(posedge clk);
  endtask
  task automatic cr(input string n, input logic [31:0] o, logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(B + o, d, r);
    chk(n, e, d);
  endtask
  task automatic t_reset;
    cr("lstat", 32'h14, 32'h60);
    cr("ident", 32'h08, 32'h01);
    cr("ienable", 32'h04, 32'h00);
    cr("frac", 32'h28, 32'h10);
    cr("ovs", 32'h2c, 32'hf0);
    cr("txen", 32'h30, 32'h80);
    cr("scratch", 32'h1c, 32'h00);
    wr(32'h0c, 32'h80);
    cr("div_lo", 32'h00, 32'h01);
    cr("div_hi", 32'h04, 32'h00);
  endtask
  task automatic t_div;
    wr(32'h00, 32'h00);
    wr(32'h0c, 32'h03);
    wr(32'h04, 32'h03);
    cr("ienable", 32'h04, 32'h03);
    cr("ident", 32'h08, 32'h02);
    wr(32'h0c, 32'h83);
    cr("div_hi", 32'h04, 32'h00);
    cr("div_lo", 32'h00, 32'h00);
    wr(32'h0c, 32'h03);
  endtask
  task automatic t_scratch;
    wr(32'h1c, 32'hffffffa5);
    cr("scratch", 32'h1c, 32'ha5);
    wr(32'h14, 32'h00);
    cr("lstat", 32'h14, 32'h60);
  endtask
  task automatic t_tx;
    int n;
    wr(32'h30, 32'h00);
    wr(32'h00, 32'h5a);
    wr(32'h00, 32'h96);
    cr("lstat", 32'h14, 32'h00);
    cr("rx_buf", 32'h00, 32'h00);
    wr(32'h30, 32'h80);
    for (n = 0; n < 800 && peer.got_q.size() < 2; n++) @(posedge clk);
    if (peer.got_q.size() < 2) stall();
    chk("tx_first", 32'h5a, 32'(peer.got_q[0]));
    chk("tx_second", 32'h96, 32'(peer.got_q[1]));
  endtask
  task automatic t_rx;
    logic [31:0] d;
    logic [1:0] r;
    d = 32'h0;
    peer.send(8'hc3, 1'h0);
    peer.send(8'h11, 1'h1);
    for (int n = 0; n < 40 && !d[0]; n++) rd(B + 32'h14, d, r);
    chk("ready", 32'h1, d & 32'h1);
    chk("frame_err", 32'h0, d & 32'h8);
    wr(32'h00, 32'h77);
    cr("rx_buf", 32'h00, 32'hc3);
    rd(B + 32'h14, d, r);
    chk("frame_err", 32'h8, d & 32'h8);
    cr("rx_buf", 32'h00, 32'h11);
  endtask
  task automatic t_unmapped;
    logic [31:0] d;
    logic [1:0] r;
    rd(B + 32'h34, d, r);
    chk("rresp", 32'(urm_pkg::RESP_SLVERR), 32'(r));
    chk("rdata", 32'h0, d);
    rd(32'h50008000, d, r);
    chk("rresp", 32'(urm_pkg::RESP_SLVERR), 32'(r));
    wr(32'h10000000, 32'h00, urm_pkg::RESP_SLVERR);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'h1;
    t_reset;
    t_div;
    t_scratch;
    t_tx;
    t_rx;
    t_unmapped;
    give_verdict;
  end
endmodule
`default_nettype wire

// ---- dv/urm_serial_peer.sv ----
// Remote serial device model on the receive and transmit lines
`timescale 1ns/10ps
`default_nettype none
module urm_serial_peer #(
  parameter int BIT_CYC = 16
) (
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  logic [7:0] got;
  logic [7:0] got_q[$];
  initial rxd = 1'h1;
  // Sends one 8N1 frame, optionally with a broken stop bit
  task automatic send(input logic [7:0] d, input logic bad_stop);
    logic [9:0] f;
    f = {~bad_stop, d, 1'h0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BIT_CYC) @(posedge clk);
    end
    rxd <= 1'h1;
  endtask
  // Samples each of the eight transmitted data bits in its middle
  always begin
    @(negedge txd);
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk);
      got[i] = txd;
    end
    repeat (BIT_CYC) @(posedge clk);
    got_q.push_back(got);
  end
endmodule
`default_nettype wire

// ---- logic/urm_fifo.sv ----
// Sixteen-entry flip-flop FIFO for serial characters
`timescale 1ns/10ps
`default_nettype none
module urm_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic flush,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] head,
  output logic empty,
  output logic full,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic do_push;
  logic do_pop;

  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign empty = (cnt_reg == '0);
  assign full = (cnt_reg == (AW+1)'(DEPTH));
  assign head = mem_reg[rd_reg];
  assign level = cnt_reg;

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_reg[wr_reg] <= push_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else if (flush) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (do_push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  fifo_level_a: assert property (@(posedge clk) disable iff (!nrst)
    cnt_reg <= (AW+1)'(DEPTH)) else $error("FIFO level over depth");
endmodule
`default_nettype wire

// ---- logic/urm_pkg.sv ----
// Package with register map, reset values and carrier types of the serial port
//
// Operation
// - Line control bit 7 selects divisor bytes instead of data and enable regs.
// - Block sits at base 0x4000_8000; unassigned offsets are reserved.
// - With select low, reading offset zero pops oldest receive FIFO character.
// - With select low, writing offset zero pushes character into transmit FIFO.
// - With select high, offsets zero and four hold divisor bytes, reset 0x01, 0.
// - With select low, offset four is interrupt enable, seven bits, reset zero.
// - Offset eight reads interrupt identification (0x01), writes FIFO control.
// - First received bit lands in bit 0; short characters zero-padded above.
// - Transmitter sends each character least significant bit first.
// - Parity, framing and break flags describe the receive FIFO head character.
// - Receive path read-only, transmit path write-only, never crossing.
// - Read-only line status at 0x014, reset 0x60.
// - Transmit enable at 0x030, reset 0x80, halts the transmitter.
// - Fractional divider at 0x028, reset 0x10, stored only; the baud divider does not use it.
// - Oversampling register at 0x02C, reset 0xF0, sets samples per bit.
// - Eight-bit scratch register at 0x01C, reset zero, no effect.
// - Reset values apply only to implemented bits.
// - Receive and transmit FIFOs hold sixteen characters each.
// - Divisor bytes form a 16-bit divisor; zero acts as one.
`default_nettype none
package urm_pkg;
  localparam logic [31:0] BASE_ADDR = 32'h4000_8000;
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_IEN = 8'h04;
  localparam logic [7:0] OFF_IID = 8'h08;
  localparam logic [7:0] OFF_LCTL = 8'h0c;
  localparam logic [7:0] OFF_MCTL = 8'h10;
  localparam logic [7:0] OFF_LSTAT = 8'h14;
  localparam logic [7:0] OFF_MSTAT = 8'h18;
  localparam logic [7:0] OFF_SCR = 8'h1c;
  localparam logic [7:0] OFF_ABD = 8'h20;
  localparam logic [7:0] OFF_IRD = 8'h24;
  localparam logic [7:0] OFF_FRAC = 8'h28;
  localparam logic [7:0] OFF_OVS = 8'h2c;
  localparam logic [7:0] OFF_TXEN = 8'h30;
  localparam logic [7:0] OFF_HDX = 8'h40;
  localparam logic [7:0] OFF_SCI = 8'h48;
  localparam logic [7:0] OFF_MDC = 8'h4c;
  localparam logic [7:0] OFF_MDA = 8'h50;
  localparam logic [7:0] OFF_MDD = 8'h54;
  localparam logic [7:0] OFF_SYNC = 8'h58;
  localparam int DIV_SEL_BIT = 7;
  localparam int TXEN_BIT = 7;
  localparam logic [7:0] RST_DIV_LO = 8'h01;
  localparam logic [7:0] RST_DIV_HI = 8'h00;
  localparam logic [7:0] RST_IID = 8'h01;
  localparam logic [7:0] RST_LSTAT = 8'h60;
  localparam logic [7:0] RST_FRAC = 8'h10;
  localparam logic [7:0] RST_OVS = 8'hf0;
  localparam logic [7:0] RST_TXEN = 8'h80;
  localparam int FIFO_DEPTH = 16;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Received character with its line error flags
  typedef struct packed {
    logic break_indication_flag;
    logic framing_error_flag;
    logic parity_error_flag;
    logic [7:0] data;
  } urm_rx_char_t;
  // Line format from line control
  typedef struct packed {
    logic [1:0] word_len;
    logic two_stop;
    logic parity_en;
    logic parity_even;
  } urm_fmt_t;
endpackage
`default_nettype wire

// ---- logic/urm_serdes.sv ----
// Bit-rate serialiser and deserialiser for one character stream
`timescale 1ns/10ps
`default_nettype none
module urm_serdes (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [15:0] divisor,
  input wire logic [3:0] ovs,
  input wire urm_pkg::urm_fmt_t fmt,
  input wire logic tx_go,
  input wire logic [7:0] tx_data,
  output logic tx_busy,
  output logic txd,
  input wire logic rxd_sync,
  output logic rx_valid,
  output urm_pkg::urm_rx_char_t rx_char
);
  logic [15:0] pre_reg;
  logic [3:0] smp_reg;
  logic tick;
  logic [10:0] tsh_reg;
  logic [3:0] tbits_reg;
  logic [3:0] rsmp_reg;
  logic [3:0] rbits_reg;
  logic [9:0] rsh_reg;
  logic rbusy_reg;
  logic [3:0] nbits;
  logic par;
  logic bit_edge;
  logic [7:0] tmask;
  logic [10:0] tframe;

  // Data bits plus optional parity
  assign nbits = 4'(5 + fmt.word_len) + 4'(fmt.parity_en);
  // Zero divisor acts as one
  assign tick = (pre_reg == 16'h0000);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pre_reg <= '0;
    end else if (tick) begin
      pre_reg <= (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001;
    end else begin
      pre_reg <= pre_reg - 16'h0001;
    end
  end

  // Oversampling count per bit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      smp_reg <= '0;
    end else if (tick) begin
      smp_reg <= (smp_reg == ovs) ? 4'h0 : smp_reg + 4'h1;
    end
  end

  assign bit_edge = tick && (smp_reg == ovs);
  assign tmask = 8'hff >> (3 - fmt.word_len);

  // Start, masked data, parity or stop, then stop ones
  always_comb begin
    par = ^(tx_data & tmask);
    par = fmt.parity_even ? par : !par;
    tframe = (11'h7ff << (nbits + 4'h1)) | {2'b00, tx_data & tmask, 1'b0};
    tframe[4'(5 + fmt.word_len) + 4'h1] = fmt.parity_en ? par : 1'b1;
  end

  // Transmit shift, LSB first
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tsh_reg <= '1;
      tbits_reg <= '0;
      txd <= 1'b1;
    end else if (tbits_reg == 4'h0) begin
      txd <= 1'b1;
      if (tx_go) begin
        // Start bit waits for the next bit boundary, full length
        tsh_reg <= tframe;
        tbits_reg <= nbits + 4'h2 + 4'(fmt.two_stop);
      end
    end else if (bit_edge) begin
      txd <= tsh_reg[0];
      tsh_reg <= {1'b1, tsh_reg[10:1]};
      tbits_reg <= tbits_reg - 4'h1;
    end
  end
  assign tx_busy = (tbits_reg != 4'h0);

  // Receive: sample at mid bit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rbusy_reg <= 1'b0;
      rsmp_reg <= '0;
      rbits_reg <= '0;
      rsh_reg <= '0;
      rx_valid <= 1'b0;
      rx_char <= '0;
    end else begin
      rx_valid <= 1'b0;
      if (!rbusy_reg) begin
        if (!rxd_sync) begin
          rbusy_reg <= 1'b1;
          rsmp_reg <= '0;
          rbits_reg <= '0;
          rsh_reg <= '0;
        end
      end else if (tick) begin
        rsmp_reg <= (rsmp_reg == ovs) ? 4'h0 : rsmp_reg + 4'h1;
        if (rsmp_reg == {1'b0, ovs[3:1]}) begin
          rbits_reg <= rbits_reg + 4'h1;
          if (rbits_reg == 4'h0 && rxd_sync) begin
            // Line high at mid start: glitch, not a start bit
            rbusy_reg <= 1'b0;
          end else if (rbits_reg == nbits + 4'h1) begin
            rbusy_reg <= 1'b0;
            rx_valid <= 1'b1;
            // First bit in bit 0, unused MSBs zero
            rx_char.data <= 8'(rsh_reg >> (10 - nbits)) &
                            (8'hff >> (3 - fmt.word_len));
            rx_char.parity_error_flag <= fmt.parity_en &&
              ((^(rsh_reg >> (10 - nbits))) != !fmt.parity_even);
            rx_char.framing_error_flag <= !rxd_sync;
            rx_char.break_indication_flag <= !rxd_sync && rsh_reg == '0;
          end else if (rbits_reg != 4'h0) begin
            rsh_reg <= {rxd_sync, rsh_reg[9:1]};
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- logic/urm_top.sv ----
// Serial port register front end with AXI4-Lite slave and FIFOs
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module urm_top #(
  parameter int FIFO_DEPTH = urm_pkg::FIFO_DEPTH,
  parameter logic [31:0] BASE = urm_pkg::BASE_ADDR
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic [31:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [31:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic RXD,
  output logic TXD
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] lctl_reg;
  logic [7:0] div_lo_reg;
  logic [7:0] div_hi_reg;
  logic [6:0] ien_reg;
  logic [7:0] mctl_reg;
  logic [7:0] scr_reg;
  logic [7:0] abd_reg;
  logic [7:0] ird_reg;
  logic [7:0] frac_reg;
  logic [7:0] ovs_reg;
  logic [7:0] txen_reg;
  logic [7:0] hdx_reg;
  logic [7:0] sci_reg;
  logic [7:0] mdc_reg;
  logic [7:0] mda_reg;
  logic [7:0] mdd_reg;
  logic [7:0] sync_reg;
  logic overrun_reg;
  logic [1:0] rxd_meta_reg;
  logic [31:0] awaddr_reg;
  logic aw_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_held_reg;
  logic wr_fire;
  logic wr_hit;
  logic [7:0] wr_off;
  logic [7:0] wbyte;
  logic rd_hit;
  logic [7:0] rd_off;
  logic [7:0] rd_val;
  logic rd_mapped;
  logic div_sel;
  logic rx_pop;
  logic tx_push;
  logic fifo_flush_rx;
  logic fifo_flush_tx;
  urm_pkg::urm_rx_char_t rx_head;
  urm_pkg::urm_rx_char_t rx_new;
  logic rx_new_valid;
  logic rx_empty;
  logic rx_full;
  logic [7:0] tx_head;
  logic tx_empty;
  logic tx_full;
  logic tx_busy;
  logic tx_go;
  logic [7:0] lstat;
  logic [7:0] iid;
  urm_pkg::urm_fmt_t fmt;

  assign div_sel = lctl_reg[urm_pkg::DIV_SEL_BIT];
  assign fmt = '{word_len: lctl_reg[1:0], two_stop: lctl_reg[2],
                 parity_en: lctl_reg[3], parity_even: lctl_reg[4]};

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rxd_meta_reg <= 2'b11;
    end else begin
      rxd_meta_reg <= {rxd_meta_reg[0], RXD};
    end
  end

  // ----------------------------------------------------------------
  // Write channel: address and data in either order
  // ----------------------------------------------------------------
  assign wr_fire = aw_held_reg && w_held_reg && !BVALID;
  assign wr_off = awaddr_reg[7:0];
  assign wr_hit = (awaddr_reg[31:8] == BASE[31:8]);
  assign wbyte = wdata_reg[7:0];

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
    end else begin
      AWREADY <= !aw_held_reg && !AWREADY && !BVALID;
      WREADY <= !w_held_reg && !WREADY && !BVALID;
      if (AWVALID && AWREADY) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_held_reg <= 1'b1;
        wdata_reg <= WDATA;
        wstrb_reg <= WSTRB;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      BVALID <= 1'b0;
      BRESP <= urm_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      BVALID <= 1'b1;
      BRESP <= wr_hit ? urm_pkg::RESP_OKAY : urm_pkg::RESP_SLVERR;
    end else if (BREADY) begin
      BVALID <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register writes (low byte lane only)
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      lctl_reg <= '0;
      div_lo_reg <= urm_pkg::RST_DIV_LO;
      div_hi_reg <= urm_pkg::RST_DIV_HI;
      ien_reg <= '0;
      mctl_reg <= '0;
      scr_reg <= '0;
      abd_reg <= '0;
      ird_reg <= '0;
      frac_reg <= urm_pkg::RST_FRAC;
      ovs_reg <= urm_pkg::RST_OVS;
      txen_reg <= urm_pkg::RST_TXEN;
      hdx_reg <= '0;
      sci_reg <= '0;
      mdc_reg <= '0;
      mda_reg <= '0;
      mdd_reg <= '0;
      sync_reg <= '0;
    end else if (wr_fire && wr_hit && wstrb_reg[0]) begin
      case (wr_off)
        urm_pkg::OFF_DATA: begin
          if (div_sel) begin
            div_lo_reg <= wbyte;
          end
        end
        urm_pkg::OFF_IEN: begin
          if (div_sel) begin
            div_hi_reg <= wbyte;
          end else begin
            ien_reg <= wbyte[6:0];
          end
        end
        urm_pkg::OFF_LCTL: lctl_reg <= wbyte;
        urm_pkg::OFF_MCTL: mctl_reg <= wbyte;
        urm_pkg::OFF_SCR: scr_reg <= wbyte;
        urm_pkg::OFF_ABD: abd_reg <= wbyte;
        urm_pkg::OFF_IRD: ird_reg <= wbyte;
        urm_pkg::OFF_FRAC: frac_reg <= wbyte;
        urm_pkg::OFF_OVS: ovs_reg <= wbyte;
        urm_pkg::OFF_TXEN: txen_reg <= wbyte & urm_pkg::RST_TXEN;
        urm_pkg::OFF_HDX: hdx_reg <= wbyte;
        urm_pkg::OFF_SCI: sci_reg <= wbyte;
        urm_pkg::OFF_MDC: mdc_reg <= wbyte;
        urm_pkg::OFF_MDA: mda_reg <= wbyte;
        urm_pkg::OFF_MDD: mdd_reg <= wbyte;
        urm_pkg::OFF_SYNC: sync_reg <= wbyte;
        default: ;
      endcase
    end
  end

  // Transmit push and FIFO control flushes
  assign tx_push = wr_fire && wr_hit && wstrb_reg[0] &&
                   wr_off == urm_pkg::OFF_DATA && !div_sel;
  assign fifo_flush_rx = wr_fire && wr_hit && wstrb_reg[0] &&
                         wr_off == urm_pkg::OFF_IID && wbyte[1];
  assign fifo_flush_tx = wr_fire && wr_hit && wstrb_reg[0] &&
                         wr_off == urm_pkg::OFF_IID && wbyte[2];

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign rd_off = ARADDR[7:0];
  assign rd_hit = (ARADDR[31:8] == BASE[31:8]);
  // Head pop only on a mapped data read with select low
  assign rx_pop = ARVALID && ARREADY && rd_hit &&
                  rd_off == urm_pkg::OFF_DATA && !div_sel;

  assign lstat = {!rx_empty && (rx_head.parity_error_flag ||
                  rx_head.framing_error_flag ||
                  rx_head.break_indication_flag),
                  tx_empty && !tx_busy, tx_empty,
                  rx_head.break_indication_flag && !rx_empty,
                  rx_head.framing_error_flag && !rx_empty,
                  rx_head.parity_error_flag && !rx_empty,
                  overrun_reg, !rx_empty};
  assign iid = (ien_reg[0] && !rx_empty) ? 8'h04 :
               (ien_reg[1] && tx_empty) ? 8'h02 : urm_pkg::RST_IID;

  always_comb begin
    rd_val = 8'h00;
    rd_mapped = 1'b1;
    case (rd_off)
      // Never returns transmit data
      urm_pkg::OFF_DATA: rd_val = div_sel ? div_lo_reg :
        (rx_empty ? 8'h00 : rx_head.data);
      urm_pkg::OFF_IEN: rd_val = div_sel ? div_hi_reg : {1'b0, ien_reg};
      urm_pkg::OFF_IID: rd_val = iid;
      urm_pkg::OFF_LCTL: rd_val = lctl_reg;
      urm_pkg::OFF_MCTL: rd_val = mctl_reg;
      urm_pkg::OFF_LSTAT: rd_val = lstat;
      urm_pkg::OFF_MSTAT: rd_val = 8'h00;
      urm_pkg::OFF_SCR: rd_val = scr_reg;
      urm_pkg::OFF_ABD: rd_val = abd_reg;
      urm_pkg::OFF_IRD: rd_val = ird_reg;
      urm_pkg::OFF_FRAC: rd_val = frac_reg;
      urm_pkg::OFF_OVS: rd_val = ovs_reg;
      urm_pkg::OFF_TXEN: rd_val = txen_reg;
      urm_pkg::OFF_HDX: rd_val = hdx_reg;
      urm_pkg::OFF_SCI: rd_val = sci_reg;
      urm_pkg::OFF_MDC: rd_val = mdc_reg;
      urm_pkg::OFF_MDA: rd_val = mda_reg;
      urm_pkg::OFF_MDD: rd_val = mdd_reg;
      urm_pkg::OFF_SYNC: rd_val = sync_reg;
      default: rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= '0;
      RRESP <= urm_pkg::RESP_OKAY;
    end else begin
      ARREADY <= !ARREADY && !RVALID && ARVALID;
      if (ARVALID && ARREADY) begin
        RVALID <= 1'b1;
        RDATA <= (rd_hit && rd_mapped) ? {24'h000000, rd_val} : 32'h0;
        RRESP <= (rd_hit && rd_mapped) ? urm_pkg::RESP_OKAY :
                 urm_pkg::RESP_SLVERR;
      end else if (RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // FIFOs and serial engine
  // ----------------------------------------------------------------
  urm_fifo #(.WIDTH(11), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk(CLK_SYS), .nrst(NRST), .flush(fifo_flush_rx),
    .push(rx_new_valid), .push_data(rx_new), .pop(rx_pop),
    .head(rx_head), .empty(rx_empty), .full(rx_full), .level());

  urm_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk(CLK_SYS), .nrst(NRST), .flush(fifo_flush_tx),
    .push(tx_push), .push_data(wbyte), .pop(tx_go),
    .head(tx_head), .empty(tx_empty), .full(tx_full), .level());

  // Transmit enable halts new characters
  assign tx_go = !tx_empty && !tx_busy && txen_reg[urm_pkg::TXEN_BIT];

  // Overrun: set wins over clear by line status read
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      overrun_reg <= 1'b0;
    end else if (rx_new_valid && rx_full) begin
      overrun_reg <= 1'b1;
    end else if (ARVALID && ARREADY && rd_hit &&
                 rd_off == urm_pkg::OFF_LSTAT) begin
      overrun_reg <= 1'b0;
    end
  end

  urm_serdes u_serdes (
    .clk(CLK_SYS), .nrst(NRST),
    .divisor({div_hi_reg, div_lo_reg}),
    .ovs(ovs_reg[7:4]), .fmt(fmt),
    .tx_go(tx_go), .tx_data(tx_head), .tx_busy(tx_busy), .txd(TXD),
    .rxd_sync(rxd_meta_reg[1]), .rx_valid(rx_new_valid), .rx_char(rx_new));

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence data_read_s;
    ARVALID && ARREADY && rd_hit && rd_off == urm_pkg::OFF_DATA;
  endsequence

  rx_head_read_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (data_read_s and !div_sel && !rx_empty) |=>
      RVALID && RDATA == {24'h0, $past(rx_head.data)})
    else $error("Data read did not return receive head");
  div_low_read_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (data_read_s and div_sel) |=> RDATA[7:0] == $past(div_lo_reg))
    else $error("Divisor low byte read wrong");
  tx_push_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    tx_push && !tx_full && !tx_go |=> !tx_empty)
    else $error("Transmit write not queued");
  div_no_pop_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    div_sel |-> !rx_pop && !tx_push)
    else $error("Data path touched with divisor selected");
  upper_zero_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    RVALID |-> RDATA[31:8] == 24'h0)
    else $error("Upper read bits not zero");
  tx_halt_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    !txen_reg[urm_pkg::TXEN_BIT] && !tx_busy |=> !tx_busy)
    else $error("Transmitter started while halted");
  sequence lstat_read_s;
    ARVALID && ARREADY && rd_hit && rd_off == urm_pkg::OFF_LSTAT;
  endsequence

  lstat_flags_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (lstat_read_s and !rx_empty) |=> RDATA[4:2] ==
      $past({rx_head.break_indication_flag, rx_head.framing_error_flag,
             rx_head.parity_error_flag}))
    else $error("Line flags not from receive head");
  unmapped_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    ARVALID && ARREADY && !rd_hit |=> RRESP == urm_pkg::RESP_SLVERR)
    else $error("Unmapped read answered okay");
  bresp_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    wr_fire && !wr_hit |=> BVALID && BRESP == urm_pkg::RESP_SLVERR)
    else $error("Outside write answered okay");
endmodule
`default_nettype wire
